// ### design/scp_pkg.sv
// Constants for the system clock prescaler block
package scp_pkg;

   // ***********************************
   // Register map (byte addresses)
   // ***********************************
   localparam logic [7:0] SCP_ADDR_PRESCALE = 8'h28;
   localparam logic [7:0] SCP_ADDR_TRIM     = 8'h2c;
   localparam logic [7:0] SCP_ADDR_STATUS   = 8'h30;

   // ***********************************
   // Field layout
   // ***********************************
   localparam int SCP_UNLOCK_BIT  = 7;
   localparam int SCP_SEL_W       = 4;
   localparam int SCP_TRIM_W      = 8;
   localparam int SCP_DIV_W       = 8;
   localparam int SCP_ST_UNLOCK   = 0;
   localparam int SCP_ST_PENDING  = 1;
   localparam int SCP_ST_ACT_LSB  = 4;

   // ***********************************
   // Reset values and codes
   // ***********************************
   localparam logic [3:0] SCP_SEL_RST_PLAIN = 4'h0;
   localparam logic [3:0] SCP_SEL_RST_DIV8  = 4'h3;
   localparam logic [3:0] SCP_SEL_MAX       = 4'h8;
   localparam logic [7:0] SCP_TRIM_RST      = 8'h00;

   // ***********************************
   // Timing
   // ***********************************
   localparam logic [2:0] SCP_UNLOCK_TICKS = 3'h4;

   // ***********************************
   // Bus handshake states
   // ***********************************
   typedef enum logic [1:0] {
      SCP_BUS_IDLE = 2'b01,
      SCP_BUS_ACK  = 2'b10
   } scp_bus_e;

endpackage

// ### design/scp_top.sv
// System clock prescaler with protected change sequence, clock output and RC trim
//
// What this block does
// - With the clock output fuse set, the divided clock overrides the pin's I/O.
// - No clock is driven on the output pin while reset is held.
// - The output pin carries the divided clock at selects 1 to 8 and holds steady high at select 0, never the undivided one.
// - One division factor feeds CPU, flash, I/O and ADC domains alike.
// - Factor changes are glitch-free; no intermediate period is shorter than both.
// - New factor starts right at the end of the old period in progress; a select written in its last cycle waits one more old period.
// - Divider counts on the master clock; its count is never readable.
// - Every reset loads the factory calibration value into all trim bits.
// - Trim writes take effect at once and steer the RC oscillator.
// - Top trim bit picks low or high range; ranges overlap.
// - Lower seven trim bits tune monotonically from 0x00 to 0x7f.
// - A new select value is accepted only while the unlock bit is set.
// - Setting unlock needs every other prescale register bit written as zero.
// - Unlock clears four cycles after setting or on select write; rewrites do nothing.
// - Prescale register bits 6 to 4 are read-only zero.
// - Select resets to 0000, or 0011 when the divide-by-eight fuse is set.
// - The unlock sequence accepts any select from 0 to 8 regardless of divide-by-eight fuse.
// - Select codes 0 to 8 divide by two to the power n; 9 to 15 reserved.
//
// Chosen here: register access over Avalon-MM.
module scp_top
   import scp_pkg::*;
#(
   parameter int TRIM_W = scp_pkg::SCP_TRIM_W,
   parameter int SEL_W  = scp_pkg::SCP_SEL_W
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // Avalon-MM slave
   input  wire logic [7:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // Fuses and factory value
   input  wire logic        clock_output_fuse,
   input  wire logic        divide_by_eight_fuse,
   input  wire logic [7:0]  factory_trim,
   // Divided clock enables per domain
   output logic             cpu_clk_en,
   output logic             flash_clk_en,
   output logic             io_clk_en,
   output logic             adc_clk_en,
   // Oscillator trim
   output logic             trim_range_bit,
   output logic [6:0]       trim_fine_field,
   // Shared I/O pin
   input  wire logic        gpio_out,
   input  wire logic        gpio_oe,
   output logic             clock_output_pin_out,
   output logic             clock_output_pin_oe
);
   import scp_pkg::*;

   // ***********************************
   // Parameter checks
   // ***********************************
   if (TRIM_W != SCP_TRIM_W) begin : g_trim_chk
      $error("Trim width must be eight");
   end
   if (SEL_W != SCP_SEL_W) begin : g_sel_chk
      $error("Select width must be four");
   end

   // ***********************************
   // Functions
   // ***********************************
   // Low bits of the counter that make up one divided period
   function automatic logic [SCP_DIV_W-1:0] period_mask(input logic [3:0] n);
      logic [SCP_DIV_W:0] one_hot;
      one_hot = '0;
      one_hot[n] = 1'b1;
      return SCP_DIV_W'(one_hot - 9'h001);
   endfunction

   // ***********************************
   // Fuse synchronisers
   // ***********************************
   logic [1:0] fuse_meta_reg;
   logic [1:0] fuse_sync_reg;
   logic [7:0] ftrim_meta_reg;
   logic [7:0] ftrim_sync_reg;

   always_ff @(posedge clock) begin
      fuse_meta_reg <= {clock_output_fuse, divide_by_eight_fuse};
      fuse_sync_reg <= fuse_meta_reg;
   end

   // Factory value is static; two stages settle it well before reset ends
   always_ff @(posedge clock) begin
      ftrim_meta_reg <= factory_trim;
      ftrim_sync_reg <= ftrim_meta_reg;
   end

   wire cko_fuse  = fuse_sync_reg[1];
   wire div8_fuse = fuse_sync_reg[0];

   // ***********************************
   // State
   // ***********************************
   scp_bus_e           bus_reg;
   logic [31:0]        rdata_reg;
   logic [3:0]         sel_reg;
   logic [3:0]         act_sel_reg;
   logic [3:0]         pend_sel_reg;
   logic               pend_reg;
   logic               unlock_reg;
   logic [2:0]         unlock_cnt_reg;
   logic [SCP_DIV_W-1:0] div_cnt_reg;
   logic               tick_reg;
   logic               phase_reg;
   logic [7:0]         trim_reg;
   logic               pin_out_reg;
   logic               pin_oe_reg;
   logic               wait_reg;

   // ***********************************
   // Bus decode
   // ***********************************
   wire req        = read | write;
   wire take       = req & (bus_reg == SCP_BUS_ACK);
   wire wr_take    = write & take;
   wire hit_ps     = address == SCP_ADDR_PRESCALE;
   wire hit_trim   = address == SCP_ADDR_TRIM;
   wire hit_st     = address == SCP_ADDR_STATUS;
   wire wr_ps      = wr_take & hit_ps;
   wire wr_trim    = wr_take & hit_trim;
   wire [3:0] wsel = writedata[3:0];
   wire w_unlock   = writedata[SCP_UNLOCK_BIT];
   wire w_rest0    = writedata[6:0] == 7'h00;
   wire set_unlock = wr_ps & w_unlock & w_rest0 & ~unlock_reg;
   wire sel_write  = wr_ps & ~w_unlock;
   wire sel_accept = sel_write & unlock_reg;
   wire sel_legal  = wsel <= SCP_SEL_MAX;
   wire sel_load   = sel_accept & sel_legal;

   // ***********************************
   // Read data
   // ***********************************
   wire [7:0] rd_ps = {unlock_reg, 3'b000, sel_reg};
   wire [7:0] rd_st = {act_sel_reg, 2'b00, pend_reg, unlock_reg};
   wire [7:0] rd_byte = hit_ps   ? rd_ps
                      : hit_trim ? trim_reg
                      : hit_st   ? rd_st
                      : 8'h00;

   // ***********************************
   // Avalon handshake
   // ***********************************
   // One wait cycle: waitrequest drops in the cycle after the request shows
   always_ff @(posedge clock) begin
      if (!nrst) begin
         bus_reg   <= SCP_BUS_IDLE;
         rdata_reg <= 32'h0000_0000;
         wait_reg  <= 1'b1;
      end else begin
         case (bus_reg)
            SCP_BUS_IDLE: begin
               if (req) begin
                  bus_reg   <= SCP_BUS_ACK;
                  rdata_reg <= {24'h00_0000, rd_byte};
                  wait_reg  <= 1'b0;
               end
            end
            SCP_BUS_ACK: begin
               bus_reg  <= SCP_BUS_IDLE;
               wait_reg <= 1'b1;
            end
            default: begin
               bus_reg  <= SCP_BUS_IDLE;
               wait_reg <= 1'b1;
            end
         endcase
      end
   end

   // ***********************************
   // Unlock window
   // ***********************************
   // Counted in divided clock cycles, as the processor sees them
   wire unlock_expire = unlock_reg & tick_reg & (unlock_cnt_reg == 3'h1);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         unlock_reg <= 1'b0;
      end else if (set_unlock) begin
         unlock_reg <= 1'b1;
      end else if (sel_write | unlock_expire) begin
         unlock_reg <= 1'b0;
      end
   end

   // Rewrites while open never reload the count
   always_ff @(posedge clock) begin
      if (!nrst) begin
         unlock_cnt_reg <= 3'h0;
      end else if (set_unlock) begin
         unlock_cnt_reg <= SCP_UNLOCK_TICKS;
      end else if (sel_write | unlock_expire) begin
         unlock_cnt_reg <= 3'h0;
      end else if (unlock_reg & tick_reg) begin
         unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
      end
   end

   // ***********************************
   // Select registers
   // ***********************************
   wire [3:0] sel_rst = div8_fuse ? SCP_SEL_RST_DIV8 : SCP_SEL_RST_PLAIN;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sel_reg <= sel_rst;
      end else if (sel_load) begin
         sel_reg <= wsel;
      end
   end

   // ***********************************
   // Divider
   // ***********************************
   wire [SCP_DIV_W-1:0] mask = period_mask(act_sel_reg);
   wire [SCP_DIV_W-1:0] half = mask >> 1;
   wire boundary = (div_cnt_reg & mask) == mask;
   // Switch only at a period boundary so no short pulse appears
   wire apply    = boundary & pend_reg & ~sel_load;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         pend_sel_reg <= sel_rst;
      end else if (sel_load) begin
         pend_sel_reg <= wsel;
      end
   end

   // A new write wins over a boundary in the same cycle; it goes pending
   always_ff @(posedge clock) begin
      if (!nrst) begin
         act_sel_reg <= sel_rst;
         pend_reg    <= 1'b0;
      end else if (sel_load) begin
         pend_reg    <= 1'b1;
      end else if (apply) begin
         act_sel_reg <= pend_sel_reg;
         pend_reg    <= 1'b0;
      end
   end

   // Count stays internal; no register path reads it
   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= boundary ? '0 : div_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= boundary;
      end
   end

   // High for the first half of each period, steady high at divide by one
   always_ff @(posedge clock) begin
      if (!nrst) begin
         phase_reg <= 1'b0;
      end else begin
         phase_reg <= (mask == '0) | ((div_cnt_reg & mask) < half) | boundary;
      end
   end

   // ***********************************
   // Domain clock enables
   // ***********************************
   logic cpu_en_reg;
   logic flash_en_reg;
   logic io_en_reg;
   logic adc_en_reg;

   // One flop per domain keeps each enable local to its own load
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cpu_en_reg <= 1'b0;
      end else begin
         cpu_en_reg <= boundary;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         flash_en_reg <= 1'b0;
      end else begin
         flash_en_reg <= boundary;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         io_en_reg <= 1'b0;
      end else begin
         io_en_reg <= boundary;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         adc_en_reg <= 1'b0;
      end else begin
         adc_en_reg <= boundary;
      end
   end

   // ***********************************
   // Oscillator trim
   // ***********************************
   // Bit 7 picks the range, bits 6:0 tune inside it; passed through unchanged
   always_ff @(posedge clock) begin
      if (!nrst) begin
         trim_reg <= ftrim_sync_reg;
      end else if (wr_trim) begin
         trim_reg <= writedata[7:0];
      end
   end

   // ***********************************
   // Clock output pin
   // ***********************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pin_out_reg <= 1'b0;
      end else if (cko_fuse) begin
         pin_out_reg <= phase_reg;
      end else begin
         pin_out_reg <= gpio_out;
      end
   end

   // Port function returns one cycle late when the fuse is clear
   always_ff @(posedge clock) begin
      if (!nrst) begin
         pin_oe_reg <= 1'b0;
      end else if (cko_fuse) begin
         pin_oe_reg <= 1'b1;
      end else begin
         pin_oe_reg <= gpio_oe;
      end
   end

   // ***********************************
   // Outputs
   // ***********************************
   assign readdata             = rdata_reg;
   assign waitrequest          = wait_reg;
   assign cpu_clk_en           = cpu_en_reg;
   assign flash_clk_en         = flash_en_reg;
   assign io_clk_en            = io_en_reg;
   assign adc_clk_en           = adc_en_reg;
   assign trim_range_bit       = trim_reg[7];
   assign trim_fine_field      = trim_reg[6:0];
   assign clock_output_pin_out = pin_out_reg;
   assign clock_output_pin_oe  = pin_oe_reg;

endmodule

// ### sim/scp_chk.sv
// Port checker for the system clock prescaler
module scp_chk
   import scp_pkg::*;
(
   // Clock and reset
   input logic        clock,
   input logic        nrst,
   // Register bus
   input logic [7:0]  address,
   input logic        read,
   input logic        write,
   input logic [31:0] writedata,
   input logic [31:0] readdata,
   input logic        waitrequest,
   // Fuses and trim
   input logic        clock_output_fuse,
   input logic        divide_by_eight_fuse,
   input logic [7:0]  factory_trim,
   input logic        trim_range_bit,
   input logic [6:0]  trim_fine_field,
   // Enables and pin
   input logic        cpu_clk_en,
   input logic        flash_clk_en,
   input logic        io_clk_en,
   input logic        adc_clk_en,
   input logic        gpio_out,
   input logic        gpio_oe,
   input logic        clock_output_pin_out,
   input logic        clock_output_pin_oe
);
   wire logic [7:0] trim_w = {trim_range_bit, trim_fine_field};
   default clocking cb @(posedge clock);
   endclocking
   // ****************
   // Assertions
   // ****************
   domains_same_a: assert property (cpu_clk_en == flash_clk_en && cpu_clk_en == io_clk_en && cpu_clk_en == adc_clk_en)
      else $error("domain enables differ");
   reset_quiet_a: assert property (!nrst |=> !clock_output_pin_oe && !cpu_clk_en)
      else $error("clock driven during reset");
   ack_once_a: assert property (disable iff (!nrst) (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");
   pin_fuse_a: assert property (disable iff (!nrst) clock_output_fuse && $past(nrst) |-> clock_output_pin_oe)
      else $error("pin not driven with fuse set");
   pin_gpio_a: assert property (disable iff (!nrst) !clock_output_fuse && $past(nrst) |->
      clock_output_pin_oe == $past(gpio_oe) && clock_output_pin_out == $past(gpio_out)) else $error("pin lost port function");
   rsv_zero_a: assert property (disable iff (!nrst) read && !waitrequest && address == SCP_ADDR_PRESCALE |->
      readdata[6:4] == 3'h0 && readdata[31:8] == 24'h0) else $error("reserved bits not zero");
   trim_write_a: assert property (disable iff (!nrst) write && !waitrequest && address == SCP_ADDR_TRIM |=>
      {24'h0, trim_w} == $past(writedata)) else $error("trim write not applied");
   trim_reset_a: assert property ((!nrst && $stable(factory_trim)) [*3] |=> trim_w == factory_trim)
      else $error("trim not loaded in reset");
   // ****************
   // Covers
   // ****************
   unlock_c: cover property (write && !waitrequest && address == SCP_ADDR_PRESCALE && writedata[7:0] == 8'h80);
   pin_c: cover property (clock_output_pin_oe && clock_output_fuse && nrst);
   trim_c: cover property (write && !waitrequest && address == SCP_ADDR_TRIM);
endmodule

bind scp_top scp_chk u_chk (.*);

// ### sim/tb_top.sv
// Self-checking testbench for the system clock prescaler
module tb_top
   import scp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clock = 1'h0, nrst = 1'h0, read = 1'h0, write = 1'h0, pin_q;
   logic [7:0]  address = 8'h00, factory_trim = 8'h00, tv;
   logic [31:0] writedata = 32'h0, readdata, expq[$];
   logic        clock_output_fuse = 1'h0, divide_by_eight_fuse = 1'h1, gpio_out = 1'h0, gpio_oe = 1'h0;
   logic        waitrequest, cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en;
   logic        trim_range_bit, clock_output_pin_out, clock_output_pin_oe;
   logic [6:0]  trim_fine_field;
   int          num_errors = 0, cmp_count = 0, en_c, pin_c, en_gap, pin_gap, npulse = 0, mingap = 999, old;
   scp_top u_dut (.*);
   initial forever #25 clock = ~clock;
   // ****************
   // Tasks
   // ****************
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge clock);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= !wr;
      do @(posedge clock); while (waitrequest !== 1'h0 && ++t < 50);
      if (t >= 50) num_errors++;
      read <= 1'h0;
      write <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      expq.push_back(exp);
      bus(1'h0, a, 8'h00);
   endtask
   task automatic chg(input logic [7:0] code);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h80);
      bus(1'h1, SCP_ADDR_PRESCALE, code);
   endtask
   task automatic ticks(input int k);
      int t0, t;
      t0 = npulse;
      t = 0;
      while (npulse < t0 + k && t++ < 3000) @(posedge clock);
   endtask
   task automatic rst(input logic fo, input logic d8);
      @(posedge clock);
      nrst <= 1'h0;
      clock_output_fuse <= fo;
      divide_by_eight_fuse <= d8;
      factory_trim <= 8'($urandom());
      repeat (12) @(posedge clock);
      nrst <= 1'h1;
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************
   // Monitors
   // ****************
   always @(posedge clock) begin
      gpio_out <= 1'($urandom());
      gpio_oe <= 1'($urandom());
   end
   // Gaps are counted in master cycles between enable pulses and pin rises
   always @(posedge clock) begin
      en_c++;
      pin_c++;
      if (cpu_clk_en === 1'h1) begin
         if (en_c < mingap) mingap = en_c;
         en_gap = en_c;
         en_c = 0;
         npulse++;
      end
      if (clock_output_pin_out === 1'h1 && pin_q !== 1'h1) begin
         pin_gap = pin_c;
         pin_c = 0;
      end
      pin_q = clock_output_pin_out;
      if (read === 1'h1 && waitrequest === 1'h0) check("readdata", readdata, expq.pop_front());
   end
   initial begin
      #(80000 * 50);
      num_errors++;
      summarize();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      tv = 8'($urandom(32'hcad5));
      rst(1'h0, 1'h1);
      rd(SCP_ADDR_PRESCALE, 32'h3);
      rd(SCP_ADDR_TRIM, {24'h0, factory_trim});
      rd(SCP_ADDR_STATUS, 32'h30);
      rd(8'h00, 32'h0);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h01);
      rd(SCP_ADDR_PRESCALE, 32'h3);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h81);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h01);
      rd(SCP_ADDR_PRESCALE, 32'h3);
      chg(8'h08);
      rd(SCP_ADDR_PRESCALE, 32'h8);
      ticks(3);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h80);
      rd(SCP_ADDR_STATUS, 32'h81);
      ticks(3);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h80);
      ticks(3);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h02);
      rd(SCP_ADDR_PRESCALE, 32'h8);
      chg(8'h09);
      rd(SCP_ADDR_PRESCALE, 32'h8);
      bus(1'h1, SCP_ADDR_PRESCALE, 8'h01);
      rd(SCP_ADDR_PRESCALE, 32'h8);
      @(negedge clock);
      foreach (expq[i]) num_errors++;
      for (int i = 0; i < 3; i++) begin
         tv = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'($urandom());
         bus(1'h1, SCP_ADDR_TRIM, tv);
         @(negedge clock);
         check("range bit", trim_range_bit, tv[7]);
         check("fine field", trim_fine_field, tv[6:0]);
         rd(SCP_ADDR_TRIM, {24'h0, tv});
      end
      rst(1'h1, 1'h0);
      rd(SCP_ADDR_PRESCALE, 32'h0);
      rd(SCP_ADDR_TRIM, {24'h0, factory_trim});
      old = 0;
      for (int n = 0; n <= 8; n++) begin
         mingap = 999;
         chg(8'(n));
         rd(SCP_ADDR_PRESCALE, n);
         ticks(4);
         check("enable gap", en_gap, 1 << n);
         check("gap floor", mingap >= (1 << ((n < old) ? n : old)), 1);
         if (n > 0) check("pin gap", pin_gap, 1 << n);
         old = n;
      end
      summarize();
   end
endmodule
